// file: hdl/overpower_function.sv
// Directional over-power protection with AHB-Lite register slave
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "overpower_consts.svh"
module overpower_function #(
    parameter int P_CYCLES_PER_MS = `OP_CLK_FREQ_KHZ * `OP_DELAY_STEP_MS
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_meas_valid,
    input wire overpower_pkg::meas_s i_meas,
    input wire logic i_general_block_in,
    input wire logic i_vt_supervision_block_in,
    output logic o_overpower_start_out,
    output logic o_overpower_trip_out,
    output logic o_irq
);
    import overpower_pkg::*;

    // ***********************************************************
    // Register bus
    // ***********************************************************
    logic wr_pend_r, wr_pend_nxt; // Write data phase pending
    logic [7:0] daddr_r, daddr_nxt; // Data phase address
    logic [1:0] ctrl_r, ctrl_nxt; // Operation on, start only
    logic signed [8:0] angle_r, angle_nxt; // Direction angle, degrees
    logic [10:0] spwr_r, spwr_nxt; // Start power, tenths of percent
    logic [15:0] delay_r, delay_nxt; // Trip delay, ms
    logic [23:0] rated_r, rated_nxt; // Rated apparent power
    logic [3:0] ev_r, ev_nxt; // Sticky events
    logic [3:0] mask_r, mask_nxt; // Event mask
    logic [3:0] ev_set; // Edge events this cycle
    logic start_r, trip_r, decision_r;
    logic addr_ok;
    logic [15:0] wdelay;
    logic [10:0] wspwr;
    logic signed [8:0] wangle;

    assign addr_ok = i_hsel && i_hready && i_htrans[1];
    assign wangle = i_hwdata[8:0];
    assign wspwr = i_hwdata[10:0];
    assign wdelay = i_hwdata[15:0];

    // Next state of bus tracking and all software registers
    always_comb begin
        wr_pend_nxt = addr_ok && i_hwrite;
        daddr_nxt = addr_ok ? i_haddr[7:0] : daddr_r;
        ctrl_nxt = ctrl_r;
        angle_nxt = angle_r;
        spwr_nxt = spwr_r;
        delay_nxt = delay_r;
        rated_nxt = rated_r;
        mask_nxt = mask_r;
        ev_nxt = ev_r | ev_set; // Set wins over a same-cycle clear
        if (wr_pend_r) begin
            case (daddr_r)
                `OP_ADDR_CTRL: ctrl_nxt = i_hwdata[1:0];
                `OP_ADDR_ANGLE: begin
                    // Out-of-range writes clamp to the nearest limit
                    if (wangle < $signed(`OP_ANGLE_MIN)) angle_nxt = `OP_ANGLE_MIN; // [R10]
                    else if (wangle > $signed(`OP_ANGLE_MAX)) angle_nxt = `OP_ANGLE_MAX; // [R10]
                    else angle_nxt = wangle;
                end
                `OP_ADDR_SPWR: begin
                    if (wspwr < `OP_SPWR_MIN) spwr_nxt = `OP_SPWR_MIN; // [R11]
                    else if (wspwr > `OP_SPWR_MAX) spwr_nxt = `OP_SPWR_MAX; // [R11]
                    else spwr_nxt = wspwr;
                end
                `OP_ADDR_DELAY: begin
                    if (wdelay < `OP_DELAY_MIN) delay_nxt = `OP_DELAY_MIN; // [R12]
                    else if (wdelay > `OP_DELAY_MAX) delay_nxt = `OP_DELAY_MAX; // [R12]
                    else delay_nxt = wdelay;
                end
                `OP_ADDR_RATED: rated_nxt = i_hwdata[23:0];
                `OP_ADDR_EVENT: ev_nxt = (ev_r & ~i_hwdata[3:0]) | ev_set; // [R17]
                `OP_ADDR_MASK: mask_nxt = i_hwdata[3:0];
                default: ; // Unmapped or read-only: ignored
            endcase
        end
    end

    // Register stage of the bus group
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_r <= 1'b0;
            daddr_r <= 8'h00;
            ctrl_r <= `OP_CTRL_RST; // [R14] [R9]
            angle_r <= `OP_ANGLE_RST; // [R10]
            spwr_r <= `OP_SPWR_RST; // [R11]
            delay_r <= `OP_DELAY_RST; // [R12]
            rated_r <= `OP_RATED_RST;
            ev_r <= 4'h0;
            mask_r <= 4'h0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            daddr_r <= daddr_nxt;
            ctrl_r <= ctrl_nxt;
            angle_r <= angle_nxt;
            spwr_r <= spwr_nxt;
            delay_r <= delay_nxt;
            rated_r <= rated_nxt;
            ev_r <= ev_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Read mux of the data phase; unmapped offsets read zero
    always_comb begin
        case (daddr_r)
            `OP_ADDR_CTRL: o_hrdata = {30'h0, ctrl_r};
            `OP_ADDR_ANGLE: o_hrdata = {{23{angle_r[8]}}, angle_r};
            `OP_ADDR_SPWR: o_hrdata = {21'h0, spwr_r};
            `OP_ADDR_DELAY: o_hrdata = {16'h0, delay_r};
            `OP_ADDR_RATED: o_hrdata = {8'h0, rated_r};
            `OP_ADDR_STATE: o_hrdata = {29'h0, decision_r, trip_r, start_r};
            `OP_ADDR_EVENT: o_hrdata = {28'h0, ev_r};
            `OP_ADDR_MASK: o_hrdata = {28'h0, mask_r};
            default: o_hrdata = 32'h0;
        endcase
    end
    assign o_hreadyout = 1'b1; // Zero wait states
    assign o_hresp = 1'b0; // Always OKAY
    assign o_irq = |(ev_r & mask_r);

    // ***********************************************************
    // Power calculation and directional decision
    // ***********************************************************
    seq_e state_r, state_nxt;
    logic signed [39:0] x_r, x_nxt, y_r, y_nxt; // Rotated power point
    logic signed [17:0] z_r, z_nxt; // Residual angle, deg * 256
    logic [3:0] iter_r, iter_nxt;
    logic decision_nxt;
    logic signed [32:0] p_ph [3];
    logic signed [32:0] q_ph [3];
    logic signed [35:0] p_sum, q_sum;
    logic signed [17:0] z0, atan_v;
    logic signed [71:0] lhs, rhs;

    // Per-phase complex power S = U * conj(I)
    for (genvar g = 0; g < 3; g++) begin : g_phase
        assign p_ph[g] = 33'(i_meas.ph[g].v_re * i_meas.ph[g].i_re) + 33'(i_meas.ph[g].v_im * i_meas.ph[g].i_im); // [R1]
        assign q_ph[g] = 33'(i_meas.ph[g].v_im * i_meas.ph[g].i_re) - 33'(i_meas.ph[g].v_re * i_meas.ph[g].i_im); // [R1]
    end
    assign p_sum = 36'(p_ph[0]) + 36'(p_ph[1]) + 36'(p_ph[2]); // [R1]
    assign q_sum = 36'(q_ph[0]) + 36'(q_ph[1]) + 36'(q_ph[2]); // [R1]
    assign z0 = {angle_r[8], angle_r, 8'h00};

    // Arctangent of 2^-i in degrees * 256
    always_comb begin
        case (iter_r)
            4'h0: atan_v = 18'h02D00;
            4'h1: atan_v = 18'h01A91;
            4'h2: atan_v = 18'h00E09;
            4'h3: atan_v = 18'h00720;
            4'h4: atan_v = 18'h00394;
            4'h5: atan_v = 18'h001CA;
            4'h6: atan_v = 18'h000E5;
            4'h7: atan_v = 18'h00073;
            4'h8: atan_v = 18'h00039;
            4'h9: atan_v = 18'h0001D;
            4'hA: atan_v = 18'h0000E;
            default: atan_v = 18'h00007;
        endcase
    end

    // Rotating S by minus the direction angle leaves its projection on the
    // S_s axis in x; the rotation gain is folded into the threshold side.
    assign lhs = 72'(x_r) * $signed(72'(`OP_LHS_SCALE)); // [R16]
    assign rhs = $signed(72'(spwr_r) * 72'(rated_r) * 72'(`OP_GAIN_NUM)
                 * 72'(start_r ? `OP_DROPOUT_PCT : `OP_PICKUP_PCT)); // [R4] [R16]

    // Sequencer: load, rotate, compare
    always_comb begin
        state_nxt = state_r;
        x_nxt = x_r;
        y_nxt = y_r;
        z_nxt = z_r;
        iter_nxt = iter_r;
        decision_nxt = decision_r;
        case (state_r)
            ST_IDLE: begin
                if (i_meas_valid) begin
                    // Beyond +-90 deg pre-rotate by 180 to stay in range
                    if (angle_r > $signed(`OP_ANGLE_QTR) || angle_r < -$signed(`OP_ANGLE_QTR)) begin
                        x_nxt = -40'(p_sum);
                        y_nxt = -40'(q_sum);
                        z_nxt = angle_r[8] ? z0 + $signed(`OP_Z_HALF) : z0 - $signed(`OP_Z_HALF); // [R2]
                    end else begin
                        x_nxt = 40'(p_sum);
                        y_nxt = 40'(q_sum);
                        z_nxt = z0; // [R2]
                    end
                    iter_nxt = 4'h0;
                    state_nxt = ST_ROTATE;
                end
            end
            ST_ROTATE: begin
                if (!z_r[17]) begin
                    x_nxt = x_r + (y_r >>> iter_r); // [R2]
                    y_nxt = y_r - (x_r >>> iter_r);
                    z_nxt = z_r - atan_v;
                end else begin
                    x_nxt = x_r - (y_r >>> iter_r); // [R2]
                    y_nxt = y_r + (x_r >>> iter_r);
                    z_nxt = z_r + atan_v;
                end
                iter_nxt = iter_r + 4'h1;
                if (iter_r == `OP_ROT_ITERS - 4'h1) state_nxt = ST_DECIDE;
            end
            ST_DECIDE: begin
                decision_nxt = lhs > rhs; // [R3]
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Register stage of the sequencer
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            x_r <= 40'h0;
            y_r <= 40'h0;
            z_r <= 18'h0;
            iter_r <= 4'h0;
            decision_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            x_r <= x_nxt;
            y_r <= y_nxt;
            z_r <= z_nxt;
            iter_r <= iter_nxt;
            decision_r <= decision_nxt;
        end
    end

    // ***********************************************************
    // Decision logic, delay timer and events
    // ***********************************************************
    logic start_nxt, trip_nxt, timing;
    logic [15:0] div_r, div_nxt, ms_r, ms_nxt;
    logic ms_tick;

    assign ms_tick = (div_r == 16'(P_CYCLES_PER_MS - 1));

    // Start gating, ms prescaler and trip timer
    always_comb begin
        // Blocked by the general input or by VT supervision
        start_nxt = ctrl_r[`OP_CTRL_OP_BIT] && decision_r && !i_general_block_in // [R5] [R14]
                    && !i_vt_supervision_block_in; // [R6] [R13]
        timing = start_nxt && !ctrl_r[`OP_CTRL_SONLY_BIT]; // [R7] [R9]
        div_nxt = (!timing || ms_tick) ? 16'h0 : div_r + 16'h1; // [R15]
        ms_nxt = !timing ? 16'h0 : ms_r; // [R15] [R14]
        if (timing && ms_tick && ms_r != 16'hFFFF) ms_nxt = ms_r + 16'h1; // [R7]
        trip_nxt = timing && (ms_r >= delay_r); // [R8] [R15]
        ev_set = 4'h0;
        ev_set[`OP_EV_START_ON] = start_nxt && !start_r; // [R17]
        ev_set[`OP_EV_START_OFF] = !start_nxt && start_r; // [R17]
        ev_set[`OP_EV_TRIP_ON] = trip_nxt && !trip_r; // [R17]
        ev_set[`OP_EV_TRIP_OFF] = !trip_nxt && trip_r; // [R17]
    end

    // Register stage of the outputs and timer
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_r <= 1'b0;
            trip_r <= 1'b0;
            div_r <= 16'h0;
            ms_r <= 16'h0;
        end else begin
            start_r <= start_nxt;
            trip_r <= trip_nxt;
            div_r <= div_nxt;
            ms_r <= ms_nxt;
        end
    end
    assign o_overpower_start_out = start_r;
    assign o_overpower_trip_out = trip_r;

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    AST_START_BLOCK: assert property (start_r |-> $past(!i_general_block_in)) // [R5]
        else $error("start while general block active");
    AST_START_VT_SUPERVISION: assert property (i_vt_supervision_block_in |=> !start_r) // [R6]
        else $error("start while VT supervision blocks");
    AST_OFF_QUIET: assert property (!ctrl_r[`OP_CTRL_OP_BIT] |=> !start_r && !trip_r && ms_r == 16'h0) // [R14]
        else $error("outputs or timer active while off");
    AST_DROP_CLEARS: assert property ($fell(start_r) |-> !trip_r && ms_r == 16'h0) // [R15]
        else $error("start drop left trip or timer");
    AST_START_ONLY: assert property (ctrl_r[`OP_CTRL_SONLY_BIT] |=> !trip_r && ms_r == 16'h0) // [R9]
        else $error("trip timing in start-only mode");
    AST_TRIP_DELAY: assert property ($rose(trip_r) |-> $past(ms_r) >= $past(delay_r) && start_r) // [R8]
        else $error("trip before delay expiry");
    AST_TIMER_RUNS: assert property (start_r && !ctrl_r[`OP_CTRL_SONLY_BIT] && ms_r == 16'h0
        ##1 start_r [*2] |-> div_r != 16'h0 || ms_r != 16'h0) // [R7]
        else $error("delay timer did not start");
    AST_DECIDE: assert property (state_r == ST_DECIDE |=> decision_r == $past(lhs > rhs)) // [R3]
        else $error("decision does not follow comparison");
    AST_DECIDE_LAT: assert property (state_r == ST_IDLE && i_meas_valid |-> ##13 state_r == ST_DECIDE) // [R2]
        else $error("rotation length wrong");
    AST_RANGES: assert property (angle_r >= $signed(`OP_ANGLE_MIN) && angle_r <= $signed(`OP_ANGLE_MAX)
        && spwr_r >= `OP_SPWR_MIN && delay_r >= `OP_DELAY_MIN) // [R10] [R11] [R12]
        else $error("setting out of range");
    AST_EVENT_ON: assert property ($rose(start_r) |-> ev_r[`OP_EV_START_ON]) // [R17]
        else $error("start event not recorded");

    COV_START: cover property ($rose(start_r));
    COV_TRIP: cover property ($rose(trip_r));
    COV_DROP: cover property ($fell(start_r) ##[1:50] $rose(start_r));
    COV_IRQ: cover property ($rose(o_irq));
endmodule // overpower_function

// file: hdl/overpower_consts.svh
// Constants of the directional over-power protection block
// Summary of operation
// R1: Compute three-phase P and Q from fundamentals
// R2: Characteristic line through S_s, perpendicular
// R3: Start when S beyond line (strictly)
// R4: While operating, threshold lowered by hysteresis
// R5: Start needs general block input inactive
// R6: Start suppressed while VT supervision blocks
// R7: Start without start-only begins delay timing
// R8: Delay expiry asserts trip output
// R9: Start-only TRUE: no trip, default FALSE
// R10: Direction angle -179..180 deg, default 0
// R11: Start power 1.0..200.0 percent, default 10.0
// R12: Trip delay 200..60000 ms, default 200
// R13: Supervision drives VT block when unreliable
// R14: Operation Off: outputs low, timer cleared
// R15: Start drop clears timer and trip
// R16: Power scaled to percent of rated
// R17: Start and trip edges reported as events
`ifndef OVERPOWER_CONSTS_SVH
`define OVERPOWER_CONSTS_SVH
// ***********************************************************
// Timing
// ***********************************************************
`define OP_CLK_FREQ_KHZ 40000
`define OP_DELAY_STEP_MS 1
// ***********************************************************
// Register byte offsets
// ***********************************************************
`define OP_ADDR_CTRL 8'h00
`define OP_ADDR_ANGLE 8'h04
`define OP_ADDR_SPWR 8'h08
`define OP_ADDR_DELAY 8'h0C
`define OP_ADDR_RATED 8'h10
`define OP_ADDR_STATE 8'h14
`define OP_ADDR_EVENT 8'h18
`define OP_ADDR_MASK 8'h1C
// ***********************************************************
// Fields, reset values and limits
// ***********************************************************
`define OP_CTRL_OP_BIT 0
`define OP_CTRL_SONLY_BIT 1
`define OP_EV_START_ON 0
`define OP_EV_START_OFF 1
`define OP_EV_TRIP_ON 2
`define OP_EV_TRIP_OFF 3
`define OP_CTRL_RST 2'h0
`define OP_ANGLE_RST 9'h000
`define OP_ANGLE_MIN 9'h14D
`define OP_ANGLE_MAX 9'h0B4
`define OP_ANGLE_QTR 9'h05A
`define OP_SPWR_RST 11'h064
`define OP_SPWR_MIN 11'h00A
`define OP_SPWR_MAX 11'h7D0
`define OP_DELAY_RST 16'h00C8
`define OP_DELAY_MIN 16'h00C8
`define OP_DELAY_MAX 16'hEA60
`define OP_RATED_RST 24'h002710
// ***********************************************************
// Rotation and comparison scaling
// ***********************************************************
`define OP_ROT_ITERS 4'hC
`define OP_Z_HALF 18'h0B400
`define OP_LHS_SCALE 34'h2540BE400
`define OP_GAIN_NUM 18'h28344
`define OP_PICKUP_PCT 7'h64
`define OP_DROPOUT_PCT 7'h5F
`endif

// file: hdl/overpower_pkg.sv
// Types shared by the over-power protection block
package overpower_pkg;
    // One phase: fundamental voltage and current phasors
    typedef struct packed {
        logic signed [15:0] v_re;
        logic signed [15:0] v_im;
        logic signed [15:0] i_re;
        logic signed [15:0] i_im;
    } phase_s;
    // Three phases of one measurement sample
    typedef struct packed {
        phase_s [2:0] ph;
    } meas_s;
    // Decision sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROTATE = 2'b01,
        ST_DECIDE = 2'b10
    } seq_e;
endpackage

// file: sim/overpower_trip_logic.sv
// Model of the trip logic and supervision beyond the block
`timescale 1ns/1ps
module overpower_trip_logic (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_trip,
    input wire logic i_vt_unreliable,
    input wire logic i_slow,
    output logic o_vt_supervision_block_in,
    output logic [7:0] o_trip_count
);
    // ***********************************
    // Supervision delay and trip counting
    // ***********************************
    logic [2:0] vt_pipe_r; // Supervision verdict history
    logic trip_prev_r; // Last trip level, for edges
    // Slow mode mimics a supervision that needs a few cycles
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            vt_pipe_r <= 3'h0;
            trip_prev_r <= 1'b0;
            o_trip_count <= 8'h00;
        end else begin
            vt_pipe_r <= {vt_pipe_r[1:0], i_vt_unreliable};
            trip_prev_r <= i_trip;
            // Count each trip command once
            if (i_trip && !trip_prev_r) begin
                o_trip_count <= o_trip_count + 8'h01;
            end
        end
    end
    // Blocks while measurement is unreliable
    assign o_vt_supervision_block_in = i_slow ? vt_pipe_r[2] : vt_pipe_r[0];
endmodule // overpower_trip_logic

// file: sim/overpower_function_tb_top.sv
// Self-checking bench of the over-power block
`timescale 1ns/1ps
`include "overpower_consts.svh"
module overpower_function_tb_top;
    import overpower_pkg::*;
    // ****************
    // Signals
    // ****************
    localparam int CPM = 4; // Short millisecond keeps trips near 800 cycles
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready;
    logic hresp;
    logic mv = 1'b0;
    meas_s meas = '0;
    logic blk = 1'b0;
    logic vt_bad = 1'b0;
    logic slow = 1'b0;
    logic vt_block;
    logic start;
    logic trip;
    logic irq;
    logic [7:0] trip_count;
    int fail_count = 0;
    int checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    overpower_function #(.P_CYCLES_PER_MS(CPM)) dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_meas_valid(mv),
        .i_meas(meas), .i_general_block_in(blk), .i_vt_supervision_block_in(vt_block),
        .o_overpower_start_out(start), .o_overpower_trip_out(trip), .o_irq(irq));
    overpower_trip_logic far_end (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_trip(trip),
        .i_vt_unreliable(vt_bad), .i_slow(slow), .o_vt_supervision_block_in(vt_block), .o_trip_count(trip_count));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single-word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, hresp}, 32'h0); // Response is always OKAY
    endtask
    // Outputs are looked at mid-cycle, once they have settled
    task automatic look(input logic s, input logic t);
        @(negedge ref_clk);
        chk({31'h0, start}, {31'h0, s});
        chk({31'h0, trip}, {31'h0, t});
    endtask
    // Equal phases, current in phase with voltage: P = 3*v*c, Q = 0
    task automatic apply(input int v, input int c);
        @(posedge ref_clk);
        for (int k = 0; k < 3; k++) begin
            meas.ph[k] <= phase_s'{16'(v), 16'h0000, 16'(c), 16'h0000};
        end
        mv <= 1'b1;
        @(posedge ref_clk);
        mv <= 1'b0;
        repeat (16) @(posedge ref_clk);
    endtask
    // Cycles from now until the trip shows, bounded
    task automatic trip_time(input int lo, input int hi);
        int n;
        n = 0;
        while (trip !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        logic [7:0] a [8] = '{`OP_ADDR_CTRL, `OP_ADDR_ANGLE, `OP_ADDR_SPWR, `OP_ADDR_DELAY, `OP_ADDR_RATED,
            `OP_ADDR_EVENT, `OP_ADDR_MASK, 8'h20};
        logic [31:0] e [8] = '{32'h0, 32'h0, 32'h64, 32'hC8, 32'h2710, 32'h0, 32'h0, 32'h0};
        for (int k = 0; k < 8; k++) begin
            rdc(a[k], e[k]);
        end
        apply(200, 4);
        look(1'b0, 1'b0);
        $display("test reset done");
    endtask
    // Out-of-range settings clamp; status is read-only
    task automatic t_limits();
        logic [7:0] a [7] = '{`OP_ADDR_ANGLE, `OP_ADDR_ANGLE, `OP_ADDR_SPWR, `OP_ADDR_SPWR, `OP_ADDR_DELAY,
            `OP_ADDR_DELAY, `OP_ADDR_STATE};
        logic [31:0] w [7] = '{32'hFFFFFF4C, 32'hB5, 32'h5, 32'h7FF, 32'h64, 32'hEA61, 32'h7};
        logic [31:0] e [7] = '{32'hFFFFFF4D, 32'hB4, 32'hA, 32'h7D0, 32'hC8, 32'hEA60, 32'h4};
        for (int k = 0; k < 7; k++) begin
            wr(a[k], w[k]);
            rdc(a[k], e[k]);
        end
        wr(`OP_ADDR_ANGLE, 32'h0);
        wr(`OP_ADDR_SPWR, 32'h64);
        wr(`OP_ADDR_DELAY, 32'hC8);
        $display("test limits done");
    endtask
    // Pickup 1000, drop-out 950: P 984 stays off, 1200 starts, 984 holds, 900 drops
    task automatic t_start_trip();
        apply(0, 0); // Clear the decision left by the reset test
        wr(`OP_ADDR_CTRL, 32'h1);
        apply(82, 4);
        look(1'b0, 1'b0);
        apply(100, 4);
        look(1'b1, 1'b0);
        trip_time(795, 806);
        apply(82, 4);
        look(1'b1, 1'b1);
        apply(75, 4);
        look(1'b0, 1'b0);
        rdc(`OP_ADDR_EVENT, 32'hF);
        chk({31'h0, irq}, 32'h0);
        wr(`OP_ADDR_MASK, 32'h1);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`OP_ADDR_EVENT, 32'h1);
        rdc(`OP_ADDR_EVENT, 32'hE);
        chk({31'h0, irq}, 32'h0);
        wr(`OP_ADDR_EVENT, 32'hF);
        wr(`OP_ADDR_MASK, 32'h0);
        $display("test start trip done");
    endtask
    // Block mid-timing restarts the timer; supervision blocks, fast and slow
    task automatic t_block();
        apply(100, 4);
        look(1'b1, 1'b0);
        repeat (400) @(posedge ref_clk);
        blk <= 1'b1;
        repeat (2) @(posedge ref_clk);
        look(1'b0, 1'b0);
        @(posedge ref_clk);
        blk <= 1'b0;
        repeat (2) @(posedge ref_clk);
        trip_time(795, 806);
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            slow <= s[0];
            vt_bad <= 1'b1;
            repeat (6) @(posedge ref_clk);
            look(1'b0, 1'b0);
            @(posedge ref_clk);
            vt_bad <= 1'b0;
            repeat (6) @(posedge ref_clk);
            look(1'b1, 1'b0);
        end
        apply(0, 0);
        look(1'b0, 1'b0);
        $display("test block done");
    endtask
    task automatic t_start_only();
        wr(`OP_ADDR_CTRL, 32'h3);
        apply(100, 4);
        look(1'b1, 1'b0);
        repeat (900) @(posedge ref_clk);
        look(1'b1, 1'b0);
        wr(`OP_ADDR_CTRL, 32'h1);
        trip_time(790, 806);
        apply(0, 0);
        look(1'b0, 1'b0);
        $display("test start only done");
    endtask
    // Line at 60 deg halves P; at 90 deg pure P never reaches it
    task automatic t_angle();
        wr(`OP_ADDR_ANGLE, 32'h3C);
        apply(100, 4);
        look(1'b0, 1'b0);
        apply(200, 4);
        look(1'b1, 1'b0);
        wr(`OP_ADDR_ANGLE, 32'h5A);
        apply(200, 4);
        look(1'b0, 1'b0);
        chk({24'h0, trip_count}, 32'h3);
        $display("test angle done");
    endtask
    // ****************
    // Sequence and verdict
    // ****************
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_limits();
        t_start_trip();
        t_block();
        t_start_only();
        t_angle();
        conclude();
    end
    // Tests need some 4100 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
endmodule // overpower_function_tb_top
